// File: common/sadc_pkg.sv
// Register map, field layout and timing constants of the converter control
package sadc_pkg;
	// Register offsets (byte addresses of the on-chip register space)
	localparam logic [7:0] SADC_OFS_CTRL1 = 8'h0e;
	localparam logic [7:0] SADC_OFS_CTRL2 = 8'h0f;
	localparam logic [7:0] SADC_OFS_RESULT = 8'h20;
	localparam logic [7:0] SADC_OFS_STATUS = 8'h21;
	// Reset values
	localparam logic [7:0] SADC_CTRL1_RST = 8'h10;
	localparam logic [7:0] SADC_CTRL2_RST = 8'h00;
	localparam logic [7:0] SADC_RESULT_RST = 8'h00;
	// Control one fields
	localparam int SADC_START_BIT = 7;
	localparam int SADC_AIN_DIS_BIT = 4;
	localparam int SADC_CHAN_MSB = 3;
	// Control two fields
	localparam int SADC_LADDER_BIT = 5;
	localparam int SADC_CTIME_MSB = 3;
	localparam int SADC_CTIME_LSB = 1;
	// Status fields
	localparam int SADC_DONE_BIT = 5;
	localparam int SADC_BUSY_BIT = 4;
	// Channel codes
	localparam logic [3:0] SADC_CHAN_FIRST = 4'h2;
	localparam logic [3:0] SADC_CHAN_LAST = 4'h5;
	// Conversion time codes and lengths in high-frequency clock periods
	localparam logic [2:0] SADC_CTIME_78 = 3'h2;
	localparam logic [2:0] SADC_CTIME_156 = 3'h3;
	localparam logic [2:0] SADC_CTIME_312 = 3'h4;
	localparam int SADC_CONV_CYC_78 = 78;
	localparam int SADC_CONV_CYC_156 = 156;
	localparam int SADC_CONV_CYC_312 = 312;
	localparam int SADC_RES_BITS = 8;
	// Filler returned on undefined or unstable read bits
	localparam logic [7:0] SADC_UNDEF_FILL = 8'h00;
endpackage : sadc_pkg

// File: design/sadc_sar_seq.sv
// Successive-approximation bit sequencer
`timescale 1ns/100ps
module sadc_sar_seq
	import sadc_pkg::*;
#(
	parameter int RES_BITS = SADC_RES_BITS
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Control
	input wire logic clear_i,
	input wire logic load_i,
	input wire logic step_i,
	// Comparator
	input wire logic cmp_i,
	// Trial word and result
	output logic [RES_BITS-1:0] trial_o,
	output logic last_o
);
	logic [RES_BITS-1:0] bit_ff;
	logic [RES_BITS-1:0] acc_ff;

	if (RES_BITS < 2) begin : g_bad_res
		$error("sadc_sar_seq: RES_BITS too small");
	end

	assign trial_o = acc_ff | bit_ff;
	assign last_o = bit_ff[0];

	// Trials run from msb to lsb
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || clear_i) begin
			bit_ff <= '0;
			acc_ff <= '0;
		end else if (load_i) begin
			bit_ff <= {1'b1, {(RES_BITS-1){1'b0}}};
			acc_ff <= '0;
		end else if (step_i && (bit_ff != '0)) begin
			if (cmp_i) begin
				acc_ff <= acc_ff | bit_ff;
			end
			bit_ff <= bit_ff >> 1;
		end
	end
endmodule : sadc_sar_seq

// File: design/sadc_ctrl.sv
// Control, status and sequencing of the 8-bit SAR converter
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module sadc_ctrl
	import sadc_pkg::*;
#(
	parameter int RES_BITS = SADC_RES_BITS,
	parameter int CNT_W = 9
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Power mode
	input wire logic stop_mode_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Analog front end
	input wire logic cmp_i,
	output logic [RES_BITS-1:0] dac_code_o,
	output logic sample_o,
	output logic [3:0] channel_select_o,
	output logic channel_valid_o,
	output logic analog_input_disable_o,
	output logic ladder_on_o,
	// Events
	output logic conv_complete_irq_o
);
	typedef enum logic [2:0] {
		SADC_IDLE = 3'b001,
		SADC_SAMPLE = 3'b010,
		SADC_CONV = 3'b100
	} sadc_state_t;

	localparam logic [CNT_W-1:0] TRIAL_78 =
		CNT_W'(SADC_CONV_CYC_78 / (RES_BITS + 1));
	localparam logic [CNT_W-1:0] TRIAL_156 =
		CNT_W'(SADC_CONV_CYC_156 / (RES_BITS + 1));
	localparam logic [CNT_W-1:0] TRIAL_312 =
		CNT_W'(SADC_CONV_CYC_312 / (RES_BITS + 1));
	// First trial absorbs the remainder so the total time is exact
	localparam logic [CNT_W-1:0] FIRST_78 =
		CNT_W'(SADC_CONV_CYC_78 - RES_BITS * int'(TRIAL_78));
	localparam logic [CNT_W-1:0] FIRST_156 =
		CNT_W'(SADC_CONV_CYC_156 - RES_BITS * int'(TRIAL_156));
	localparam logic [CNT_W-1:0] FIRST_312 =
		CNT_W'(SADC_CONV_CYC_312 - RES_BITS * int'(TRIAL_312));

	// Channel valid value that reset leaves
	localparam logic CHAN_RST_VALID =
		(SADC_CTRL1_RST[SADC_CHAN_MSB:0] >= SADC_CHAN_FIRST) &&
		(SADC_CTRL1_RST[SADC_CHAN_MSB:0] <= SADC_CHAN_LAST);

	// Parameter checks at elaboration
	if (RES_BITS != 8) begin : g_bad_res
		$error("sadc_ctrl: only 8-bit results");
	end
	if ((1 << CNT_W) <= SADC_CONV_CYC_312) begin : g_bad_cnt
		$error("sadc_ctrl: CNT_W too small");
	end
	if (SADC_CONV_CYC_78 / (RES_BITS + 1) < 2) begin : g_bad_trial
		$error("sadc_ctrl: trial too short");
	end

	sadc_state_t state_ff;
	sadc_state_t nxt_state;
	logic [7:0] ctrl1_ff;
	logic [7:0] ctrl2_ff;
	logic [7:0] result_ff;
	logic done_ff;
	logic busy_ff;
	logic irq_ff;
	logic [7:0] rdata_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] trial_len;
	logic stop_s1_ff;
	logic stop_ff;
	logic wr_ctrl1;
	logic wr_ctrl2;
	logic rd_result;
	logic start_req;
	logic tick;
	logic seq_load;
	logic seq_last;
	logic finish;
	logic [RES_BITS-1:0] trial;
	logic [RES_BITS-1:0] final_word;
	logic [CNT_W-1:0] first_len;
	logic [3:0] wr_chan;
	logic chan_valid_ff;
	logic ladder_ff;
	logic sample_ff;

	// Stop mode indication comes from the clock controller pins
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			stop_s1_ff <= 1'b0;
			stop_ff <= 1'b0;
		end else begin
			stop_s1_ff <= stop_mode_i;
			stop_ff <= stop_s1_ff;
		end
	end

	// Register decode; writes blocked while stopped
	assign wr_ctrl1 = reg_wr_i && !stop_ff && (reg_addr_i == SADC_OFS_CTRL1);
	assign wr_ctrl2 = reg_wr_i && !stop_ff && (reg_addr_i == SADC_OFS_CTRL2);
	assign rd_result = reg_rd_i && (reg_addr_i == SADC_OFS_RESULT);
	assign start_req = wr_ctrl1 && reg_wdata_i[SADC_START_BIT];
	assign wr_chan = reg_wdata_i[SADC_CHAN_MSB:0];

	// Conversion time select
	always_comb begin
		unique case (ctrl2_ff[SADC_CTIME_MSB:SADC_CTIME_LSB])
			SADC_CTIME_78: begin
				trial_len = TRIAL_78;
				first_len = FIRST_78;
			end
			SADC_CTIME_156: begin
				trial_len = TRIAL_156;
				first_len = FIRST_156;
			end
			SADC_CTIME_312: begin
				trial_len = TRIAL_312;
				first_len = FIRST_312;
			end
			default: begin
				trial_len = TRIAL_312;
				first_len = FIRST_312;
			end
		endcase
	end

	assign tick = (cnt_ff == '0);

	// Last trial bit is decided by the comparator at the final edge
	assign final_word = {trial[RES_BITS-1:1], cmp_i};

	// Sequencer state
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		seq_load = 1'b0;
		finish = 1'b0;
		unique case (state_ff)
			SADC_IDLE: begin
				if (start_req) begin
					nxt_state = SADC_SAMPLE;
					nxt_cnt = trial_len - CNT_W'(1);
				end
			end
			SADC_SAMPLE: begin
				if (tick) begin
					nxt_state = SADC_CONV;
					nxt_cnt = first_len - CNT_W'(1);
					seq_load = 1'b1;
				end else begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			SADC_CONV: begin
				if (tick && seq_last) begin
					nxt_state = SADC_IDLE;
					finish = 1'b1;
				end else if (tick) begin
					nxt_cnt = trial_len - CNT_W'(1);
				end else begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			default: nxt_state = SADC_IDLE;
		endcase
	end

	// Stop aborts and does not restart
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || stop_ff) begin
			state_ff <= SADC_IDLE;
			cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	sadc_sar_seq #(
		.RES_BITS(RES_BITS)
	) u_seq (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.clear_i(stop_ff),
		.load_i(seq_load),
		.step_i(tick && (state_ff == SADC_CONV)),
		.cmp_i(cmp_i),
		.trial_o(trial),
		.last_o(seq_last)
	);

	// Control one: reset and stop init, start bit not stored
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || stop_ff) begin
			ctrl1_ff <= SADC_CTRL1_RST;
		end else if (wr_ctrl1) begin
			ctrl1_ff <= {1'b0, reg_wdata_i[6:0]};
		end
	end

	// Control two
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || stop_ff) begin
			ctrl2_ff <= SADC_CTRL2_RST;
		end else if (wr_ctrl2) begin
			ctrl2_ff <= reg_wdata_i;
		end
	end

	// Result store on completion
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || stop_ff) begin
			result_ff <= SADC_RESULT_RST;
		end else if (finish) begin
			result_ff <= final_word;
		end
	end

	// Done flag: completion wins over result read
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || stop_ff) begin
			done_ff <= 1'b0;
		end else if (finish) begin
			done_ff <= 1'b1;
		end else if (rd_result || start_req) begin
			done_ff <= 1'b0;
		end
	end

	// Busy flag
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || stop_ff) begin
			busy_ff <= 1'b0;
		end else if (finish) begin
			busy_ff <= 1'b0;
		end else if (start_req && state_ff == SADC_IDLE) begin
			busy_ff <= 1'b1;
		end
	end

	// Interrupt pulse beside result store
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || stop_ff) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= finish;
		end
	end

	// Sample window output from a flop
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || stop_ff) begin
			sample_ff <= 1'b0;
		end else begin
			sample_ff <= (nxt_state == SADC_SAMPLE);
		end
	end

	// Ladder during conversion or always
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || stop_ff) begin
			ladder_ff <= SADC_CTRL2_RST[SADC_LADDER_BIT];
		end else if (wr_ctrl2) begin
			ladder_ff <= reg_wdata_i[SADC_LADDER_BIT] ||
				(nxt_state != SADC_IDLE);
		end else begin
			ladder_ff <= ctrl2_ff[SADC_LADDER_BIT] ||
				(nxt_state != SADC_IDLE);
		end
	end

	// Only codes 2 to 5 route an input
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i || stop_ff) begin
			chan_valid_ff <= CHAN_RST_VALID;
		end else if (wr_ctrl1) begin
			chan_valid_ff <= (wr_chan >= SADC_CHAN_FIRST) &&
				(wr_chan <= SADC_CHAN_LAST);
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				SADC_OFS_CTRL1: rdata_ff <= ctrl1_ff;
				SADC_OFS_CTRL2: rdata_ff <= {SADC_UNDEF_FILL[7:6],
					ctrl2_ff[5:0]};
				SADC_OFS_RESULT: rdata_ff <= result_ff;
				SADC_OFS_STATUS: rdata_ff <= {SADC_UNDEF_FILL[7:6],
					done_ff, busy_ff, SADC_UNDEF_FILL[3:0]};
				default: rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign conv_complete_irq_o = irq_ff;
	assign dac_code_o = trial;
	assign sample_o = sample_ff;
	assign channel_select_o = ctrl1_ff[SADC_CHAN_MSB:0];
	assign channel_valid_o = chan_valid_ff;
	assign analog_input_disable_o = ctrl1_ff[SADC_AIN_DIS_BIT];
	assign ladder_on_o = ladder_ff;
endmodule : sadc_ctrl

// File: verif/sadc_ctrl_asserts.sv
// Property checker for the converter control block
`timescale 1ns/100ps
module sadc_chk
	import sadc_pkg::*;
(
	// Clock, reset, mode
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic stop_mode_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Front end, events
	input wire logic sample_o,
	input wire logic [3:0] channel_select_o,
	input wire logic channel_valid_o,
	input wire logic analog_input_disable_o,
	input wire logic ladder_on_o,
	input wire logic conv_complete_irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	logic [8:0] smp_ff;
	logic [7:0] wd_ff;
	sequence stop_held; stop_mode_i[*5]; endsequence
	sequence rd_at(logic [7:0] a); reg_rd_i && reg_addr_i == a; endsequence
	always_ff @(posedge clk_sys_i) begin
		smp_ff <= (sample_o && nrst_i) ? smp_ff + 9'h001 : 9'h000;
	end
	always_ff @(posedge clk_sys_i) begin
		wd_ff <= reg_wdata_i;
	end
	start_reads_zero_a: assert property (rd_at(SADC_OFS_CTRL1) |=> !reg_rdata_o[7])
		else $error("start bit read back set");
	ctrl2_undef_a: assert property (rd_at(SADC_OFS_CTRL2) |=> reg_rdata_o[7:6] == 2'h0)
		else $error("control two top bits not filler");
	status_fill_a: assert property (rd_at(SADC_OFS_STATUS) |=> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[3:0] == 4'h0)
		else $error("status spare bits not filler");
	chan_valid_a: assert property (channel_valid_o == (channel_select_o >= SADC_CHAN_FIRST && channel_select_o <= SADC_CHAN_LAST))
		else $error("channel valid mismatch");
	ctrl1_write_a: assert property (!stop_mode_i[*3] ##0 (reg_wr_i && reg_addr_i == SADC_OFS_CTRL1) |=> analog_input_disable_o == wd_ff[4] && channel_select_o == wd_ff[3:0])
		else $error("control one write lost");
	stop_init_a: assert property (stop_held |-> channel_select_o == 4'h0 && analog_input_disable_o)
		else $error("stop did not initialise control");
	stop_abort_a: assert property (stop_held |-> !sample_o && !ladder_on_o)
		else $error("stop did not abort");
	irq_pulse_a: assert property (conv_complete_irq_o |=> !conv_complete_irq_o)
		else $error("irq longer than one cycle");
	reset_vals_a: assert property ($rose(nrst_i) |-> analog_input_disable_o && channel_select_o == 4'h0 && !sample_o)
		else $error("reset values wrong");
	sample_len_a: assert property (smp_ff <= 9'h022)
		else $error("sample phase too long");
endmodule : sadc_chk

bind sadc_ctrl sadc_chk u_chk (.clk_sys_i, .nrst_i, .stop_mode_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sample_o,
	.channel_select_o, .channel_valid_o, .analog_input_disable_o,
	.ladder_on_o, .conv_complete_irq_o);

// File: verif/sar_adc_control_8bit_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module sar_adc_control_8bit_test
	import sadc_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic stop_mode_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic cmp_i = 1'b0;
	logic [7:0] reg_rdata_o, dac_code_o;
	logic [3:0] channel_select_o;
	logic sample_o, channel_valid_o, analog_input_disable_o;
	logic ladder_on_o, conv_complete_irq_o;
	logic [7:0] vin = 8'h00;
	logic [7:0] prev = 8'h00;
	int errors = 0;
	int tests_run = 0;
	int irqs = 0;
	always #50 clk_sys_i = ~clk_sys_i;
	// Comparator stand-in and irq counter
	always @(posedge clk_sys_i) begin
		cmp_i <= (vin >= dac_code_o);
		if (conv_complete_irq_o === 1'b1) irqs <= irqs + 1;
	end
	sadc_ctrl uut (.clk_sys_i, .nrst_i, .stop_mode_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cmp_i,
		.dac_code_o, .sample_o, .channel_select_o, .channel_valid_o,
		.analog_input_disable_o, .ladder_on_o, .conv_complete_irq_o);
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask : rd
	task automatic reset_vals;
		logic [7:0] d;
		logic [7:0] ra [5] = '{SADC_OFS_CTRL1, SADC_OFS_CTRL2,
			SADC_OFS_RESULT, SADC_OFS_STATUS, 8'h30};
		logic [7:0] rv [5] = '{SADC_CTRL1_RST, SADC_CTRL2_RST,
			SADC_RESULT_RST, 8'h00, 8'h00};
		foreach (ra[i]) begin
			rd(ra[i], d);
			chk(d, rv[i]);
		end
		$display("register values test done");
	endtask : reset_vals
	task automatic conv(input logic [2:0] tc, input logic [3:0] ch,
		input logic lad, input logic [7:0] v, input logic keep);
		logic [7:0] d;
		int n;
		int len;
		int base;
		len = (tc == SADC_CTIME_78) ? SADC_CONV_CYC_78 :
			(tc == SADC_CTIME_156) ? SADC_CONV_CYC_156 : SADC_CONV_CYC_312;
		base = irqs;
		vin = v;
		wr(SADC_OFS_CTRL2, {2'b00, lad, 1'b1, tc, 1'b0});
		wr(SADC_OFS_CTRL1, {4'ha, ch});
		rd(SADC_OFS_CTRL1, d);
		chk(d & 8'h9f, {4'h0, ch});
		rd(SADC_OFS_STATUS, d);
		chk(d, 8'h10);
		chk({7'h00, ladder_on_o}, 8'h01);
		rd(SADC_OFS_RESULT, d);
		chk(d, prev);
		n = 0;
		do begin
			rd(SADC_OFS_STATUS, d);
			n++;
		end while (d[5] !== 1'b1 && n < 400);
		chk(d, 8'h20);
		chk({7'h00, 2 * n + 6 > len && 2 * n + 6 <= len + 2}, 8'h01);
		chk({7'h00, ladder_on_o}, {7'h00, lad});
		repeat (2) @(posedge clk_sys_i);
		chk(8'(irqs - base), 8'h01);
		prev = v;
		if (!keep) begin
			rd(SADC_OFS_RESULT, d);
			chk(d, v);
			rd(SADC_OFS_STATUS, d);
			chk(d, 8'h00);
		end
		$display("conversion code %0d test done", tc);
	endtask : conv
	initial begin
		logic [7:0] d;
		repeat (12) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		reset_vals();
		for (int c = 0; c < 16; c++) begin
			wr(SADC_OFS_CTRL1, {4'h2, 4'(c)});
			#1;
			chk({7'h00, channel_valid_o},
				{7'h00, 4'(c) >= SADC_CHAN_FIRST && 4'(c) <= SADC_CHAN_LAST});
			chk({7'h00, analog_input_disable_o}, 8'h00);
		end
		wr(SADC_OFS_CTRL1, 8'h32);
		#1;
		chk({7'h00, analog_input_disable_o}, 8'h01);
		$display("channel test done");
		conv(SADC_CTIME_78, 4'h2, 1'b0, 8'ha5, 1'b1);
		conv(SADC_CTIME_156, 4'h3, 1'b0, 8'h00, 1'b0);
		conv(SADC_CTIME_312, 4'h5, 1'b1, 8'hff, 1'b0);
		conv(3'h6, 4'h3, 1'b0, 8'h5a, 1'b0);
		wr(SADC_OFS_CTRL1, 8'ha4);
		repeat (20) @(posedge clk_sys_i);
		stop_mode_i <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		wr(SADC_OFS_CTRL1, 8'h25);
		stop_mode_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		prev = 8'h00;
		reset_vals();
		repeat (400) @(posedge clk_sys_i);
		rd(SADC_OFS_STATUS, d);
		chk(d, 8'h00);
		$display("stop test done");
		conv(SADC_CTIME_78, 4'h4, 1'b0, 8'h3c, 1'b0);
		close_out();
	end
	initial begin
		#3_000_000;
		errors++;
		close_out();
	end
endmodule : sar_adc_control_8bit_test
